/* File: rtl/crf_core.sv */
// Purpose: register file, ALU select, fetch pipe, PC and return stack
// Assumes: program memory answers the address in the same cycle
// Notes: flag semantics kept minimal (zero and carry only)
//
// What this block does
// - An internal 1 MHz RC clock may replace the external oscillator.
// - Select fuse 0 picks RC clock; 1, the default, picks external unless EXT_OSC_CLK_OK is low.
// - Only the parallel programming path may change the select fuse.
// - 32 byte registers; two reads and one write in one cycle.
// - ALU works register-register, register-constant and single register.
// - Next word is fetched while the current word executes.
// - Each program word is one complete 16-bit instruction.
// - Program counter is 9 bits, covering 512 words.
// - Immediate and load-immediate forms reach only registers 16 to 31.
// - Register 30 holds the index for indirect register access.
// - Two-register ops read both and write the destination.
// - I/O forms take a 6-bit location and a register field.
// - The I/O space has 64 locations.
// - Relative jump and call go to PC plus offset plus one.
// - Relative targets wrap within 9 bits, reaching all 512 words.
// - A 3-level 9-bit hardware stack holds return addresses.
// - Call or interrupt pushes into level 0, shifting deeper.
// - Return pops level 0 into PC, shifting levels up.
// - Beyond three nested pushes the oldest address is lost silently.
// - Each source has a vector; lower vector address wins.
// - Interrupts need global enable plus per-source enable.
// - Reset vector is lowest; external interrupt follows it.
// - Accepting an interrupt clears global enable; its return sets it.
`timescale 1ns/1ps
`include "crf_defs.svh"
module crf_core
  import crf_pkg::*;
#(
  parameter int NUM_REGS = 32,
  parameter int NUM_IRQ = 3,
  parameter int STACK_DEPTH = `CRF_STACK_DEPTH
)(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic EXT_OSC_CLK_OK,
  input wire logic [15:0] PROG_DATA,
  output logic [8:0] PROG_ADDR,
  input wire logic [NUM_IRQ-1:0] IRQ_PENDING,
  input wire logic [NUM_IRQ-1:0] IRQ_ENABLE,
  input wire logic [7:0] IO_RDATA,
  output logic [5:0] IO_ADDR,
  output logic [7:0] IO_WDATA,
  output logic IO_WR,
  output logic IO_RD,
  input wire logic PAR_PROG_WR,
  input wire logic PAR_PROG_VAL,
  input wire logic SER_PROG_WR,
  output logic RC_CLOCK_SELECT_FUSE,
  output logic CLK_SEL_RC,
  output logic [7:0] STATUS,
  output logic [8:0] PC,
  output logic IRQ_TAKEN
);
  localparam int RC_FREQ_MHZ = `CRF_RC_FREQ_MHZ;

  logic [7:0] regs [NUM_REGS];
  logic [8:0] stack [STACK_DEPTH];
  logic [15:0] instr;
  logic instr_valid;
  logic [7:0] sreg;
  logic [8:0] pc;
  logic [8:0] fetch_pc;
  logic fuse;
  // Unused side-band kept so a serial write is visibly ignored
  logic ser_seen;

  // Decode fields of the executing word
  crf_op_e op;
  logic [4:0] dst_idx;
  logic [4:0] src_idx;
  logic [7:0] imm;
  logic [5:0] io_loc;
  logic [11:0] rel_k;
  logic [7:0] d_val;
  logic [7:0] r_val;
  logic [7:0] b_val;
  logic [8:0] alu_sum;
  logic [7:0] alu_res;
  logic wr_en;
  logic [4:0] wr_idx;
  logic [7:0] wr_val;
  logic do_call;
  logic do_ret;
  logic do_interrupt_return_instr;
  logic do_jump;
  logic irq_go;
  logic [8:0] irq_vec;
  logic [8:0] next_pc;
  logic [8:0] rel_target;

  // Lowest index wins: vectors rise with the index
  function automatic logic [8:0] pick_vec(input logic [NUM_IRQ-1:0] req);
    logic [8:0] v;
    v = `CRF_VEC_FIRST_IRQ;
    for (int i = NUM_IRQ - 1; i >= 0; i--)
    begin
      if (req[i])
        v = 9'(`CRF_VEC_FIRST_IRQ + i);
    end
    return v;
  endfunction

  // Relative target, wraps inside the counter width
  function automatic logic [8:0] rel_addr(input logic [8:0] base,
                                          input logic [11:0] k);
    logic [11:0] s;
    s = 12'(base) + k + 12'h001;
    return s[8:0];
  endfunction

  // Instruction field split; all fields from one 16-bit word
  always_comb
  begin
    op = crf_op_e'(instr[15:12]);
    dst_idx = instr[8:4];
    src_idx = {instr[9], instr[3:0]};
    imm = {instr[11:8], instr[3:0]};
    io_loc = {instr[10:9], instr[3:0]};
    rel_k = instr[11:0];
    if (op >= CRF_OP_SUB_IMM && op <= CRF_OP_LOAD_IMM)
      dst_idx = {1'b1, instr[7:4]};
  end

  // Two read ports feed the ALU in the same cycle as the write
  always_comb
  begin
    d_val = regs[dst_idx];
    r_val = regs[src_idx];
    b_val = r_val;
    if (op >= CRF_OP_SUB_IMM && op <= CRF_OP_OR_IMM)
      b_val = imm;
    alu_sum = 9'h000;
    alu_res = 8'h00;
    case (op)
      CRF_OP_ALU_RR:
      begin
        alu_sum = {1'b0, d_val} + {1'b0, b_val};
        alu_res = alu_sum[7:0];
      end
      CRF_OP_SUB_IMM, CRF_OP_CMP_IMM:
      begin
        alu_sum = {1'b0, d_val} - {1'b0, b_val};
        alu_res = alu_sum[7:0];
      end
      CRF_OP_SBC_IMM:
      begin
        alu_sum = {1'b0, d_val} - {1'b0, b_val} - {8'h00, sreg[0]};
        alu_res = alu_sum[7:0];
      end
      CRF_OP_AND_IMM: alu_res = d_val & b_val;
      CRF_OP_OR_IMM: alu_res = d_val | b_val;
      CRF_OP_SINGLE: alu_res = ~d_val;
      default: alu_res = b_val;
    endcase
  end

  // Write-back select; compare writes nothing
  always_comb
  begin
    wr_en = 1'b0;
    wr_idx = dst_idx;
    wr_val = alu_res;
    if (instr_valid && !irq_go)
    begin
      case (op)
        CRF_OP_ALU_RR, CRF_OP_SINGLE, CRF_OP_SUB_IMM, CRF_OP_SBC_IMM,
        CRF_OP_AND_IMM, CRF_OP_OR_IMM: wr_en = 1'b1;
        CRF_OP_MOV_RR: wr_en = 1'b1;
        CRF_OP_LOAD_IMM:
        begin
          wr_en = 1'b1;
          wr_val = imm;
        end
        CRF_OP_LD_IND:
        begin
          wr_en = 1'b1;
          wr_val = regs[regs[`CRF_PTR_REG][4:0]];
        end
        CRF_OP_ST_IND:
        begin
          wr_en = 1'b1;
          wr_idx = regs[`CRF_PTR_REG][4:0];
          wr_val = d_val;
        end
        CRF_OP_IO_IN:
        begin
          wr_en = 1'b1;
          wr_val = IO_RDATA;
        end
        default: wr_en = 1'b0;
      endcase
    end
  end

  // Flow control and interrupt acceptance
  always_comb
  begin
    do_jump = instr_valid && op == CRF_OP_RELATIVE_JUMP_INSTR && !instr[12];
    do_call = instr_valid && op == CRF_OP_MISC && instr[11:10] == 2'h0;
    do_ret = instr_valid && op == CRF_OP_MISC && instr[11:10] == 2'h1;
    do_interrupt_return_instr = instr_valid && op == CRF_OP_MISC && instr[11:10] == 2'h2;
    // Only a live slot may be interrupted: a flushed slot's pc is stale
    irq_go = instr_valid && sreg[`CRF_SREG_IE_BIT]
             && |(IRQ_PENDING & IRQ_ENABLE);
    irq_vec = pick_vec(IRQ_PENDING & IRQ_ENABLE);
    rel_target = rel_addr(pc, {{2{instr[9]}}, instr[9:0]});
    if (op == CRF_OP_RELATIVE_JUMP_INSTR)
      rel_target = rel_addr(pc, rel_k);
    next_pc = 9'(fetch_pc + 9'h001);
    if (irq_go)
      next_pc = irq_vec;
    else if (do_jump || do_call)
      next_pc = rel_target;
    else if (do_ret || do_interrupt_return_instr)
      next_pc = stack[0];
  end

  // Register file, one write per cycle
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        regs[i] <= 8'h00;
    end
    else if (wr_en)
      regs[wr_idx] <= wr_val;
  end

  // Status: zero and carry plus global enable
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      sreg <= 8'h00;
    else if (irq_go)
      sreg[`CRF_SREG_IE_BIT] <= 1'b0;
    else if (do_interrupt_return_instr)
      sreg[`CRF_SREG_IE_BIT] <= 1'b1;
    else if (instr_valid && op == CRF_OP_IO_OUT && io_loc == 6'h3F)
      sreg <= d_val;
    else if (instr_valid && op >= CRF_OP_SUB_IMM && op <= CRF_OP_CMP_IMM)
    begin
      sreg[0] <= alu_sum[8];
      sreg[1] <= alu_res == 8'h00;
    end
  end

  // Two-stage pipe: fetch next word while current executes
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      fetch_pc <= `CRF_VEC_RESET;
      pc <= `CRF_PC_RESET;
      instr <= 16'h0000;
      instr_valid <= 1'b0;
    end
    else
    begin
      fetch_pc <= next_pc;
      pc <= fetch_pc;
      instr <= PROG_DATA;
      // Redirect flushes the prefetched word
      instr_valid <= !(irq_go || do_jump || do_call || do_ret || do_interrupt_return_instr);
    end
  end

  // Return stack; overflow drops the oldest, pop keeps the deepest
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      for (int i = 0; i < STACK_DEPTH; i++)
        stack[i] <= 9'h000;
    end
    else if (irq_go || do_call)
    begin
      stack[0] <= irq_go ? pc : 9'(pc + 9'h001);
      for (int i = 1; i < STACK_DEPTH; i++)
        stack[i] <= stack[i-1];
    end
    else if (do_ret || do_interrupt_return_instr)
    begin
      for (int i = 0; i < STACK_DEPTH - 1; i++)
        stack[i] <= stack[i+1];
    end
  end

  // Clock-select fuse: parallel path only
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      ser_seen <= 1'b0;
    else
      ser_seen <= SER_PROG_WR;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      fuse <= `CRF_FUSE_RESET;
    else if (PAR_PROG_WR)
      fuse <= PAR_PROG_VAL;
  end

  // Registered outputs
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      PROG_ADDR <= `CRF_PC_RESET;
      IO_ADDR <= 6'h00;
      IO_WDATA <= 8'h00;
      IO_WR <= 1'b0;
      IO_RD <= 1'b0;
      RC_CLOCK_SELECT_FUSE <= `CRF_FUSE_RESET;
      CLK_SEL_RC <= 1'b0;
      STATUS <= 8'h00;
      PC <= `CRF_PC_RESET;
      IRQ_TAKEN <= 1'b0;
    end
    else
    begin
      PROG_ADDR <= next_pc;
      IO_ADDR <= io_loc;
      IO_WDATA <= d_val;
      IO_WR <= instr_valid && !irq_go && op == CRF_OP_IO_OUT;
      IO_RD <= instr_valid && !irq_go && op == CRF_OP_IO_IN;
      RC_CLOCK_SELECT_FUSE <= fuse;
      // RC wins when fuse is 0, or when external clock missing
      CLK_SEL_RC <= !fuse || (!EXT_OSC_CLK_OK && 1'(RC_FREQ_MHZ));
      STATUS <= sreg;
      PC <= pc;
      IRQ_TAKEN <= irq_go;
    end
  end
endmodule

/* File: rtl/crf_defs.svh */
// Purpose: constants for the core datapath and return stack
// Assumes: 100 MHz system clock, 16-bit instruction words
// Notes: opcode fields follow a small coined encoding
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH
`define CRF_RC_FREQ_MHZ 1
`define CRF_PC_W 9
`define CRF_PC_RESET 9'h000
`define CRF_VEC_RESET 9'h000
`define CRF_VEC_FIRST_IRQ 9'h001
`define CRF_PTR_REG 5'h1E
`define CRF_STACK_DEPTH 3
`define CRF_IO_ADDR_W 6
`define CRF_SREG_IE_BIT 7
`define CRF_FUSE_RESET 1'h1
`endif

/* File: rtl/crf_pkg.sv */
// Purpose: types shared by the core datapath
// Assumes: crf_defs.svh holds the numbers
// Notes: opcode classes use the top nibble of the word
package crf_pkg;
  typedef enum logic [3:0] {
    CRF_OP_NOP = 4'h0,
    CRF_OP_ALU_RR = 4'h1,
    CRF_OP_MOV_RR = 4'h2,
    CRF_OP_SINGLE = 4'h3,
    CRF_OP_LD_IND = 4'h4,
    CRF_OP_ST_IND = 4'h5,
    CRF_OP_IO_IN = 4'h6,
    CRF_OP_IO_OUT = 4'h7,
    CRF_OP_SUB_IMM = 4'h8,
    CRF_OP_SBC_IMM = 4'h9,
    CRF_OP_CMP_IMM = 4'hA,
    CRF_OP_AND_IMM = 4'hB,
    CRF_OP_OR_IMM = 4'hC,
    CRF_OP_LOAD_IMM = 4'hD,
    CRF_OP_RELATIVE_JUMP_INSTR = 4'hE,
    CRF_OP_MISC = 4'hF
  } crf_op_e;
  typedef enum logic [1:0] {
    CRF_ALU_ADD = 2'h0,
    CRF_ALU_SUB = 2'h1,
    CRF_ALU_AND = 2'h2,
    CRF_ALU_OR = 2'h3
  } crf_alu_e;
endpackage

/* File: test/crf_core_chk.sv */
// Purpose: port checks of the core
// Assumes: one clock, sync active-low reset
// Notes: stack contents are judged by the bench
`timescale 1ns/1ps
module crf_core_chk
#(
  parameter int NUM_IRQ = 3
)(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic EXT_OSC_CLK_OK,
  input wire logic [NUM_IRQ-1:0] IRQ_PENDING,
  input wire logic [NUM_IRQ-1:0] IRQ_ENABLE,
  input wire logic PAR_PROG_WR,
  input wire logic SER_PROG_WR,
  input wire logic RC_CLOCK_SELECT_FUSE,
  input wire logic CLK_SEL_RC,
  input wire logic [7:0] STATUS,
  input wire logic [8:0] PC,
  input wire logic [8:0] PROG_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic IRQ_TAKEN
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Interrupt sequences: three cycles with no enabled request, arrival at a vector
  sequence s_no_req;
    ((IRQ_PENDING & IRQ_ENABLE) == '0) [*3];
  endsequence
  sequence s_vector;
    ##[0:2] (PC inside {9'h001, 9'h002, 9'h003});
  endsequence
  property p_fuse_ser;
    SER_PROG_WR && !PAR_PROG_WR |=> $stable(RC_CLOCK_SELECT_FUSE);
  endproperty
  a_fuse_ser: assert property (p_fuse_ser)
    else $error("fuse moved on serial write");
  property p_rc_sel;
    !RC_CLOCK_SELECT_FUSE || !$past(EXT_OSC_CLK_OK) |-> CLK_SEL_RC;
  endproperty
  a_rc_sel: assert property (p_rc_sel)
    else $error("rc clock not chosen");
  property p_ext_sel;
    RC_CLOCK_SELECT_FUSE && $past(EXT_OSC_CLK_OK) |-> !CLK_SEL_RC;
  endproperty
  a_ext_sel: assert property (p_ext_sel)
    else $error("external clock not chosen");
  property p_irq_clear;
    IRQ_TAKEN |=> !STATUS[7];
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("global enable kept on entry");
  property p_irq_ie;
    !STATUS[7] [*3] |-> !IRQ_TAKEN;
  endproperty
  a_irq_ie: assert property (p_irq_ie)
    else $error("interrupt with global enable off");
  property p_irq_en;
    s_no_req |-> !IRQ_TAKEN;
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt with no enabled source");
  property p_vector;
    $rose(IRQ_TAKEN) |-> s_vector;
  endproperty
  a_vector: assert property (p_vector)
    else $error("no vector after interrupt");
  property p_io_excl;
    !(IO_WR && IO_RD);
  endproperty
  a_io_excl: assert property (p_io_excl)
    else $error("read and write together");
  property p_reset_fetch;
    $rose(RESET_N) |-> PROG_ADDR == 9'h000 && !STATUS[7];
  endproperty
  a_reset_fetch: assert property (p_reset_fetch)
    else $error("bad state after reset");
endmodule
bind crf_core crf_core_chk #(.NUM_IRQ(NUM_IRQ)) i_crf_core_chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .EXT_OSC_CLK_OK(EXT_OSC_CLK_OK),
  .IRQ_PENDING(IRQ_PENDING), .IRQ_ENABLE(IRQ_ENABLE),
  .PAR_PROG_WR(PAR_PROG_WR), .SER_PROG_WR(SER_PROG_WR),
  .RC_CLOCK_SELECT_FUSE(RC_CLOCK_SELECT_FUSE), .CLK_SEL_RC(CLK_SEL_RC),
  .STATUS(STATUS), .PC(PC), .PROG_ADDR(PROG_ADDR), .IO_WR(IO_WR),
  .IO_RD(IO_RD), .IRQ_TAKEN(IRQ_TAKEN));

/* File: test/crf_prog_mem.sv */
// Purpose: program memory and I/O space model
// Assumes: word answers the address in the same cycle
// Notes: I/O reads give an address pattern
`timescale 1ns/1ps
module crf_prog_mem
(
  input wire logic clk,
  input wire logic [8:0] prog_addr,
  output logic [15:0] prog_data,
  input wire logic [5:0] io_addr,
  output logic [7:0] io_rdata
);
  logic [15:0] mem [512];
  // Async read: the core registers the word itself, one word per address
  assign prog_data = mem[prog_addr];
  // Pattern follows location so stale data shows
  assign io_rdata = {2'h0, io_addr} ^ 8'hA5;
endmodule

/* File: test/tb.sv */
// Purpose: self-checking bench for the core
// Assumes: programs loaded into the memory model
// Notes: registers are seen through I/O writes
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_ok = 1'b1;
  logic par_wr = 1'b0;
  logic par_val = 1'b1;
  logic ser_wr = 1'b0;
  logic [2:0] irq_pend = 3'h0;
  logic [2:0] irq_en = 3'h0;
  logic [15:0] prog_data;
  logic [8:0] prog_addr, pc;
  logic [7:0] io_rdata, io_wdata, status;
  logic [5:0] io_addr;
  logic io_wr, io_rd, fuse, clk_rc, irq_taken;
  int num_errors = 0;
  int checked = 0;
  crf_core i_crf_core (.CORE_CLK(clk), .RESET_N(rst_n),
    .EXT_OSC_CLK_OK(ext_ok), .PROG_DATA(prog_data), .PROG_ADDR(prog_addr),
    .IRQ_PENDING(irq_pend), .IRQ_ENABLE(irq_en), .IO_RDATA(io_rdata),
    .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_WR(io_wr), .IO_RD(io_rd),
    .PAR_PROG_WR(par_wr), .PAR_PROG_VAL(par_val), .SER_PROG_WR(ser_wr),
    .RC_CLOCK_SELECT_FUSE(fuse), .CLK_SEL_RC(clk_rc), .STATUS(status),
    .PC(pc), .IRQ_TAKEN(irq_taken));
  crf_prog_mem i_crf_prog_mem (.clk(clk), .prog_addr(prog_addr),
    .prog_data(prog_data), .io_addr(io_addr), .io_rdata(io_rdata));
  // Free-running 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Unused words spin in place so a stray fetch stays put
  task automatic wipe();
    cyc(1);
    rst_n <= 1'b0;
    for (int a = 0; a < 512; a++)
      i_crf_prog_mem.mem[a] = 16'hEFFF;
  endtask
  task automatic put(input int a, input logic [15:0] w);
    i_crf_prog_mem.mem[a] = w;
  endtask
  task automatic run();
    cyc(2);
    rst_n <= 1'b1;
  endtask
  // Bounded wait for the next I/O write strobe
  task automatic wait_io(input logic [5:0] loc, input logic [7:0] d,
    input logic chk_d);
    int n;
    n = 0;
    @(negedge clk);
    while (io_wr !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    check("io strobe", {15'h0, io_wr}, 16'h1);
    check("io location", {10'h0, io_addr}, {10'h0, loc});
    if (chk_d)
      check("io data", {8'h0, io_wdata}, {8'h0, d});
  endtask
  task automatic t_fuse();
    check("fuse reset", {15'h0, fuse}, 16'h1);
    par_val <= 1'b0;
    ser_wr <= 1'b1;
    cyc(1);
    ser_wr <= 1'b0;
    cyc(3);
    check("fuse serial", {15'h0, fuse}, 16'h1);
    par_wr <= 1'b1;
    cyc(1);
    par_wr <= 1'b0;
    cyc(3);
    check("rc select", {15'h0, clk_rc}, 16'h1);
    par_val <= 1'b1;
    par_wr <= 1'b1;
    cyc(1);
    par_wr <= 1'b0;
    ext_ok <= 1'b0;
    cyc(3);
    check("rc no osc", {15'h0, clk_rc}, 16'h1);
    ext_ok <= 1'b1;
    cyc(3);
    check("ext select", {15'h0, clk_rc}, 16'h0);
    $display("test fuse done");
  endtask
  // Wrapping jump skips word 4; immediates reach R16 and up
  task automatic t_alu();
    wipe();
    put(0, 16'hD102); put(1, 16'hD314); put(2, 16'h1301);
    put(3, 16'hE801); put(4, 16'h7106); put(5, 16'hD1E1);
    put(6, 16'h4120); put(7, 16'h7105); put(8, 16'h752A);
    put(9, 16'hB00F); put(10, 16'hC300); put(11, 16'h8001);
    put(12, 16'h7105); put(13, 16'h2340); put(14, 16'h3140);
    put(15, 16'h7146);
    run();
    wait_io(6'h05, 8'h46, 1'b1);
    wait_io(6'h2A, 8'h34, 1'b1);
    wait_io(6'h05, 8'h35, 1'b1);
    wait_io(6'h06, 8'hCA, 1'b1);
    $display("test datapath done");
  endtask
  // Four nested calls; outermost return address is lost
  task automatic t_stack();
    logic [5:0] exp_loc [5];
    exp_loc = '{6'h4, 6'h3, 6'h2, 6'h2, 6'h2};
    wipe();
    for (int i = 0; i < 4; i++)
    begin
      put(i * 10, 16'hF009);
      put(i * 10 + 1, 16'h7001 + 16'(i));
      put(i * 10 + 2, 16'hF400);
    end
    put(40, 16'hF400);
    run();
    foreach (exp_loc[i])
      wait_io(exp_loc[i], 8'h00, 1'b0);
    $display("test stack done");
  endtask
  task automatic t_irq();
    wipe();
    put(0, 16'hE003); put(1, 16'hE006); put(2, 16'hE007);
    put(3, 16'hE008); put(4, 16'hD800); put(5, 16'h770F);
    for (int v = 1; v <= 3; v++)
    begin
      put(6 + 2 * v, 16'h7000 + 16'(v));
      put(7 + 2 * v, 16'hF800);
    end
    irq_en <= 3'b110;
    run();
    wait_io(6'h3F, 8'h80, 1'b1);
    irq_pend <= 3'b111;
    wait_io(6'h02, 8'h00, 1'b0);
    irq_pend <= 3'b000;
    cyc(8);
    check("global enable", {15'h0, status[7]}, 16'h1);
    irq_pend <= 3'b101;
    wait_io(6'h03, 8'h00, 1'b0);
    irq_pend <= 3'b000;
    cyc(8);
    irq_en <= 3'b111;
    irq_pend <= 3'b111;
    wait_io(6'h01, 8'h00, 1'b0);
    irq_pend <= 3'b000;
    $display("test interrupt done");
  endtask
  initial
  begin
    wipe();
    cyc(11);
    rst_n <= 1'b1;
    cyc(2);
    t_fuse();
    t_alu();
    t_stack();
    t_irq();
    close_out();
  end
  // Hang guard, well past the expected run length
  initial
  begin
    cyc(5000);
    num_errors++;
    close_out();
  end
endmodule
